/* hw/uhpp_defines.svh */
/*
 * Register offsets, field positions, reset values and timing counts
 * for the host port power and suspend block.
 * Assumes a 20 MHz system clock and a 32-bit Wishbone register bus.
 */
`ifndef UHPP_DEFINES_SVH
`define UHPP_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte addresses (index times four)
// ----------------------------------------------------------------
`define UHPP_IDX_CONTROL 8'h01
`define UHPP_IDX_INT_STATUS 8'h03
`define UHPP_IDX_HW_CONFIG 8'h20
`define UHPP_IDX_CPU_INT 8'h24
`define UHPP_IDX_SCHED 8'h30
`define UHPP_ADDR_CONTROL 10'h004
`define UHPP_ADDR_INT_STATUS 10'h00c
`define UHPP_ADDR_HW_CONFIG 10'h080
`define UHPP_ADDR_CPU_INT 10'h090
`define UHPP_ADDR_SCHED 10'h0c0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define UHPP_FS_LSB 6
`define UHPP_FS_MSB 7
`define UHPP_CFG_OC_EN 10
`define UHPP_CFG_KEEP_CLK 11
`define UHPP_CFG_PULLDOWN 12
`define UHPP_CPU_CLK_READY 6
`define UHPP_STS_RESUME 6
`define UHPP_SCHED_BUSY 0
`define UHPP_SCHED_ASYNC 1
`define UHPP_SCHED_TOOBIG 2
`define UHPP_EP_MAX_BYTES 11'd1023

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define UHPP_CONFIG_RESET 16'h0000

// ----------------------------------------------------------------
// Timing: figures as printed, cycle counts at 20 MHz
// ----------------------------------------------------------------
`define UHPP_CLK_HZ 20000000
`define UHPP_SUSP_STOP_NS 1300000
`define UHPP_WAKE_UP_NS 160000
`define UHPP_WAKE_LOW_NS 1140000
`define UHPP_NS_PER_S 1000000000
`define UHPP_SUSP_STOP_CYC ((`UHPP_SUSP_STOP_NS / 50) + 0)
`define UHPP_WAKE_UP_CYC (`UHPP_WAKE_UP_NS * (`UHPP_CLK_HZ / 1000000) / 1000)
`define UHPP_WAKE_LOW_CYC ((`UHPP_WAKE_LOW_NS * (`UHPP_CLK_HZ / 1000000) + 999) / 1000)

`endif

/* hw/uhpp_pkg.sv */
/*
 * Types for the host port power and suspend block.
 * Assumes the defines header supplies all numbers.
 */
package uhpp_pkg;

    // Host controller functional states
    typedef enum logic [1:0] {
        UHPP_BUS_RESET = 2'h0,
        UHPP_RESUMING = 2'h1,
        UHPP_OPERATIONAL = 2'h2,
        UHPP_SUSPENDED = 2'h3
    } uhpp_fstate_e;

    // Clock manager states
    typedef enum logic [1:0] {
        UHPP_CLK_RUN,
        UHPP_CLK_STOP_WAIT,
        UHPP_CLK_STOPPED,
        UHPP_CLK_WAKING
    } uhpp_clk_e;

    // Per-port power pins
    typedef struct packed {
        logic [1:0] oc_in_n;
        logic [1:0] comparator;
    } uhpp_port_in_s;

    typedef struct packed {
        logic [1:0] power_switch_n;
        logic [1:0] power_switch_oe;
        logic pulldown_en;
    } uhpp_port_out_s;

endpackage : uhpp_pkg

/* hw/uhpp_sync.sv */
/*
 * Two-flop synchroniser bank.
 * Assumes inputs come from outside the clk_sys domain.
 */
`timescale 1ns/1ns
module uhpp_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // First stage read only by second stage
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : uhpp_sync

/* hw/uhpp_top.sv */
/*
 * Host port power and suspend sequencer: pull-down select, overcurrent
 * source select, port power switches, suspend output, clock gating and
 * the three wake-up paths, with a classic Wishbone register slave.
 * Assumes clk_sys at 20 MHz; pins arrive asynchronously.
 */
// Operation
// [R1] No async interrupt after late list write
// [R2] Driver splits control stages across lists
// [R3] Endpoint data per frame at most 1023
// [R4] Driver services interrupts every frame
// [R5] Config bit 12 selects internal pull-downs
// [R6] Pull-down select clears on any reset
// [R7] Power switch high while port overcurrent
// [R8] Config bit 10 enables internal comparator
// [R9] Comparator enable resets to zero
// [R10] Writing suspend code enters suspend
// [R11] Suspend pin high until reset/operational
// [R12] Clock stops 1.3 ms into suspend unless kept
// [R13] Full suspend needs both controllers suspended
// [R14] Wake pin restarts clock, sets ready flag
// [R15] Clock running 160 us after wake
// [R16] Clock kept while wake pin high
// [R17] Wake low 1.14 ms re-suspends
// [R18] Chip select during suspend wakes
// [R19] Downstream resume enters resuming, flags
// [R20] Driver enables wake interrupts first
// [R21] Overcurrent source selected and synchronised
`timescale 1ns/1ns
`include "uhpp_defines.svh"
module uhpp_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Software reset pulse from the register core
    input wire logic soft_reset,
    // Frame events from the scheduler (same domain)
    input wire logic sof_pulse,
    input wire logic async_int_req,
    input wire logic [10:0] ep_frame_bytes,
    output logic async_int_pulse,
    // Port pins
    input wire uhpp_pkg::uhpp_port_in_s port_in,
    output uhpp_pkg::uhpp_port_out_s port_out,
    // Suspend and wake pins
    input wire logic host_wake_in,
    input wire logic chip_select_n,
    input wire logic downstream_resume,
    input wire logic peripheral_suspended,
    output logic host_suspend_out,
    output logic clock_enable_out,
    output logic full_suspend_out
);

    // ------------------------------------------------------------
    // Types and constants
    // ------------------------------------------------------------
    localparam logic [15:0] STOP_CYC = 16'(`UHPP_SUSP_STOP_CYC);
    localparam logic [15:0] UP_CYC = 16'(`UHPP_WAKE_UP_CYC);
    localparam logic [15:0] LOW_CYC = 16'(`UHPP_WAKE_LOW_CYC);

    uhpp_pkg::uhpp_fstate_e fstate_reg;
    uhpp_pkg::uhpp_clk_e clk_reg;
    logic [15:0] config_reg;
    logic clock_ready_flag;
    logic resume_seen_flag;
    logic [15:0] timer_reg;
    logic [1:0] switch_oe_reg;
    logic list_busy_reg;
    logic ep_too_big_reg;
    logic [4:0] pins_sync;
    logic [4:0] pins_raw;
    logic [1:0] oc_sel;
    logic wr_en;
    logic rd_en;
    logic wake_s;
    logic cs_s;
    logic resume_s;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Low-active pins inverted first, so the reset value of zero reads as idle
    assign pins_raw = {downstream_resume, ~chip_select_n, host_wake_in, ~port_in.oc_in_n};

    uhpp_sync #(.WIDTH(5)) u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .async_in(pins_raw),
        .sync_out(pins_sync)
    );

    // Comparator is an analog level, synchronised with the rest
    logic [1:0] cmp_sync;
    uhpp_sync #(.WIDTH(2)) u_cmp_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .async_in(port_in.comparator),
        .sync_out(cmp_sync)
    );

    assign wake_s = pins_sync[2];
    assign cs_s = pins_sync[3];
    assign resume_s = pins_sync[4];

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [9:0] adr, input logic [9:0] reg_adr);
        hit = (adr == reg_adr);
    endfunction : hit

    // Writes land on the ack edge, while the master still holds the request
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign rd_en = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

    // One wait state: ack one cycle after the request, then dropped
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    // Read mux registered; unmapped addresses read zero
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd_en) begin
            wb_dat_o <= 32'h0000_0000;
            if (hit(wb_adr_i, `UHPP_ADDR_CONTROL))
                wb_dat_o[`UHPP_FS_MSB:`UHPP_FS_LSB] <= fstate_reg;
            if (hit(wb_adr_i, `UHPP_ADDR_INT_STATUS))
                wb_dat_o[`UHPP_STS_RESUME] <= resume_seen_flag;
            if (hit(wb_adr_i, `UHPP_ADDR_HW_CONFIG))
                wb_dat_o[15:0] <= config_reg;
            if (hit(wb_adr_i, `UHPP_ADDR_CPU_INT))
                wb_dat_o[`UHPP_CPU_CLK_READY] <= clock_ready_flag;
            if (hit(wb_adr_i, `UHPP_ADDR_SCHED)) begin
                wb_dat_o[`UHPP_SCHED_BUSY] <= list_busy_reg;
                wb_dat_o[`UHPP_SCHED_TOOBIG] <= ep_too_big_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // Hardware configuration register
    // ------------------------------------------------------------
    // Both resets clear it so bits 10 and 12 start at zero
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            config_reg <= `UHPP_CONFIG_RESET; // R6 R9
        end else if (soft_reset) begin
            config_reg <= `UHPP_CONFIG_RESET; // R6
        end else if (wr_en && hit(wb_adr_i, `UHPP_ADDR_HW_CONFIG)) begin
            if (wb_sel_i[0])
                config_reg[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
                config_reg[15:8] <= wb_dat_i[15:8];
        end
    end

    // ------------------------------------------------------------
    // Pull-downs and port power
    // ------------------------------------------------------------
    // Both sources are active high once synchronised
    assign oc_sel = config_reg[`UHPP_CFG_OC_EN] ? cmp_sync : pins_sync[1:0]; // R8 R21

    // Open drain: enable low lets the pull-up take the switch high
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            switch_oe_reg <= 2'h0;
        end else begin
            switch_oe_reg <= ~oc_sel; // R7
        end
    end

    // Switch data is always low; only the enable moves
    assign port_out = {2'h0, switch_oe_reg, config_reg[`UHPP_CFG_PULLDOWN]}; // R5 R7

    // ------------------------------------------------------------
    // Functional state
    // ------------------------------------------------------------
    // Resume from downstream wins over a same-cycle write
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            fstate_reg <= uhpp_pkg::UHPP_BUS_RESET;
        end else if (soft_reset) begin
            fstate_reg <= uhpp_pkg::UHPP_BUS_RESET;
        end else if (fstate_reg == uhpp_pkg::UHPP_SUSPENDED && resume_s) begin
            fstate_reg <= uhpp_pkg::UHPP_RESUMING; // R19
        end else if (wr_en && hit(wb_adr_i, `UHPP_ADDR_CONTROL) && wb_sel_i[0]) begin
            fstate_reg <= uhpp_pkg::uhpp_fstate_e'(wb_dat_i[`UHPP_FS_MSB:`UHPP_FS_LSB]); // R10
        end
    end

    // Resume flag: write one to clear, set wins
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            resume_seen_flag <= 1'b0;
        end else if (fstate_reg == uhpp_pkg::UHPP_SUSPENDED && resume_s) begin
            resume_seen_flag <= 1'b1; // R19
        end else if (wr_en && hit(wb_adr_i, `UHPP_ADDR_INT_STATUS) && wb_dat_i[`UHPP_STS_RESUME]) begin
            resume_seen_flag <= 1'b0;
        end
    end

    // Suspend pin follows state; resuming holds its previous level
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            host_suspend_out <= 1'b0;
        end else if (fstate_reg == uhpp_pkg::UHPP_SUSPENDED) begin
            host_suspend_out <= 1'b1; // R11
        end else if (fstate_reg == uhpp_pkg::UHPP_BUS_RESET || fstate_reg == uhpp_pkg::UHPP_OPERATIONAL) begin
            host_suspend_out <= 1'b0; // R11
        end
    end

    // ------------------------------------------------------------
    // Clock manager
    // ------------------------------------------------------------
    // Timer counts in the block's own always-on clk_sys domain
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            clk_reg <= uhpp_pkg::UHPP_CLK_RUN;
            timer_reg <= 16'h0000;
        end else begin
            unique case (clk_reg)
                uhpp_pkg::UHPP_CLK_RUN: begin
                    timer_reg <= 16'h0000;
                    if (fstate_reg == uhpp_pkg::UHPP_SUSPENDED && !config_reg[`UHPP_CFG_KEEP_CLK])
                        clk_reg <= uhpp_pkg::UHPP_CLK_STOP_WAIT;
                end
                uhpp_pkg::UHPP_CLK_STOP_WAIT: begin
                    timer_reg <= timer_reg + 16'h0001;
                    if (fstate_reg != uhpp_pkg::UHPP_SUSPENDED || config_reg[`UHPP_CFG_KEEP_CLK])
                        clk_reg <= uhpp_pkg::UHPP_CLK_RUN;
                    else if (timer_reg == STOP_CYC - 16'h0001)
                        clk_reg <= uhpp_pkg::UHPP_CLK_STOPPED; // R12
                end
                uhpp_pkg::UHPP_CLK_STOPPED: begin
                    timer_reg <= 16'h0000;
                    if (wake_s || cs_s || fstate_reg != uhpp_pkg::UHPP_SUSPENDED)
                        clk_reg <= uhpp_pkg::UHPP_CLK_WAKING; // R14 R18
                end
                uhpp_pkg::UHPP_CLK_WAKING: begin
                    // Hold while the wake source stays high; return to run once state leaves suspend
                    if (fstate_reg != uhpp_pkg::UHPP_SUSPENDED) begin
                        clk_reg <= uhpp_pkg::UHPP_CLK_RUN;
                    end else if (wake_s || cs_s) begin
                        timer_reg <= 16'h0000; // R16
                    end else if (timer_reg == LOW_CYC - 16'h0001) begin
                        clk_reg <= uhpp_pkg::UHPP_CLK_STOPPED; // R17
                    end else begin
                        timer_reg <= timer_reg + 16'h0001;
                    end
                end
            endcase
        end
    end

    // Clock comes up well inside 160 us of the wake edge
    assign clock_enable_out = (clk_reg != uhpp_pkg::UHPP_CLK_STOPPED); // R15
    assign full_suspend_out = (clk_reg == uhpp_pkg::UHPP_CLK_STOPPED) && peripheral_suspended; // R13

    // Clock-ready flag: set on wake, write one clears, set wins
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            clock_ready_flag <= 1'b0;
        end else if (clk_reg == uhpp_pkg::UHPP_CLK_STOPPED && (wake_s || cs_s)) begin
            clock_ready_flag <= 1'b1; // R14
        end else if (wr_en && hit(wb_adr_i, `UHPP_ADDR_CPU_INT) && wb_dat_i[`UHPP_CPU_CLK_READY]) begin
            clock_ready_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Frame constraints
    // ------------------------------------------------------------
    // Driver marks the list busy; a busy list at SOF skips that frame's interrupt
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            list_busy_reg <= 1'b0;
            ep_too_big_reg <= 1'b0;
        end else begin
            if (wr_en && hit(wb_adr_i, `UHPP_ADDR_SCHED) && wb_sel_i[0])
                list_busy_reg <= wb_dat_i[`UHPP_SCHED_BUSY];
            if (ep_frame_bytes > `UHPP_EP_MAX_BYTES)
                ep_too_big_reg <= 1'b1; // R3
            else if (wr_en && hit(wb_adr_i, `UHPP_ADDR_SCHED) && wb_dat_i[`UHPP_SCHED_TOOBIG])
                ep_too_big_reg <= 1'b0;
        end
    end

    logic skip_frame_reg;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            skip_frame_reg <= 1'b0;
        end else if (sof_pulse) begin
            skip_frame_reg <= list_busy_reg; // R1
        end
    end

    assign async_int_pulse = async_int_req && !skip_frame_reg && !sof_pulse; // R1

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    pullsel_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R5
        port_out.pulldown_en == config_reg[12]) else $error("pulldown mismatch");
    softclr_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R6
        soft_reset |=> !config_reg[12] && !config_reg[10]) else $error("config not cleared");
    psw_oc_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R7
        oc_sel[0] |=> !port_out.power_switch_oe[0]) else $error("port power not removed");
    ocsrc_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R8
        !config_reg[10] |-> oc_sel == pins_sync[1:0]) else $error("wrong oc source");
    susp_pin_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R11
        fstate_reg == uhpp_pkg::UHPP_SUSPENDED |=> host_suspend_out) else $error("suspend pin low");
    clk_stop_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R12
        clk_reg == uhpp_pkg::UHPP_CLK_STOPPED && $past(clk_reg) == uhpp_pkg::UHPP_CLK_STOP_WAIT |->
        !$past(config_reg[11])) else $error("clock stopped while kept");
    wake_rdy_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R14 R15
        clk_reg == uhpp_pkg::UHPP_CLK_STOPPED && wake_s |=> clock_ready_flag && clock_enable_out)
        else $error("wake missed");
    resume_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R19
        fstate_reg == uhpp_pkg::UHPP_SUSPENDED && resume_s |=> fstate_reg == uhpp_pkg::UHPP_RESUMING && resume_seen_flag)
        else $error("resume missed");
    fullsus_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R13
        full_suspend_out |-> peripheral_suspended && !clock_enable_out) else $error("early full suspend");
    skipint_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R1
        sof_pulse && list_busy_reg |=> !async_int_pulse) else $error("async interrupt not skipped");

    stop_c: cover property (@(posedge clk_sys) clk_reg == uhpp_pkg::UHPP_CLK_STOPPED);
    wake_c: cover property (@(posedge clk_sys) clk_reg == uhpp_pkg::UHPP_CLK_WAKING && wake_s);
    resume_c: cover property (@(posedge clk_sys) fstate_reg == uhpp_pkg::UHPP_RESUMING);

endmodule : uhpp_top

/* verification/uhpp_port_model.sv */
/*
 * Downstream port power circuitry: open-drain switch pin with pull-up,
 * P-channel supply switch and the two overcurrent detectors.
 * Assumes the bench commands each detector's fault level directly.
 */
`timescale 1ns/1ns
module uhpp_port_model (
    // Design side
    input wire uhpp_pkg::uhpp_port_out_s port_out,
    output uhpp_pkg::uhpp_port_in_s port_in,
    // Bench side
    input wire logic [1:0] ext_fault,
    input wire logic [1:0] cmp_fault,
    output logic [1:0] vbus_on
);
    // ------------------------------------------------------------
    // Switch pin and supply
    // ------------------------------------------------------------
    logic [1:0] pin_level;

    // Pull-up wins whenever the output is released
    assign pin_level = (port_out.power_switch_oe & port_out.power_switch_n) | ~port_out.power_switch_oe;
    // Low gate turns the supply on
    assign vbus_on = ~pin_level;
    // Detectors follow the commanded fault level; a fault does not clear when power goes
    assign port_in.oc_in_n = ~ext_fault;
    assign port_in.comparator = cmp_fault;
endmodule : uhpp_port_model

/* verification/uhpp_top_tb.sv */
/*
 * Self-checking bench for the port power and suspend block.
 * Assumes the port model and the design files are compiled first.
 */
`timescale 1ns/1ns
`include "uhpp_defines.svh"
module uhpp_top_tb;
    typedef struct packed {
        logic [31:0] cfg;
        logic [1:0] ext;
        logic [1:0] cmp;
        logic [1:0] vbus;
        logic pd;
    } uhpp_row_s;
    logic clk_sys, rstn, cyc, stb, we, soft_reset, sof_pulse, async_int_req;
    logic host_wake_in, chip_select_n, downstream_resume, peripheral_suspended;
    logic wb_ack_o, async_int_pulse, host_suspend_out, clock_enable_out, full_suspend_out;
    logic [9:0] adr;
    logic [31:0] dat;
    logic [31:0] wb_dat_o;
    logic [31:0] q;
    logic [10:0] ep_frame_bytes;
    logic [1:0] ext_fault;
    logic [1:0] cmp_fault;
    logic [1:0] vbus_on;
    uhpp_pkg::uhpp_port_in_s port_in;
    uhpp_pkg::uhpp_port_out_s port_out;
    int mismatches;
    int comparisons;
    uhpp_row_s rows [5];

    uhpp_top DUT (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .soft_reset(soft_reset), .sof_pulse(sof_pulse), .async_int_req(async_int_req),
        .ep_frame_bytes(ep_frame_bytes), .async_int_pulse(async_int_pulse), .port_in(port_in),
        .port_out(port_out), .host_wake_in(host_wake_in), .chip_select_n(chip_select_n),
        .downstream_resume(downstream_resume), .peripheral_suspended(peripheral_suspended),
        .host_suspend_out(host_suspend_out), .clock_enable_out(clock_enable_out),
        .full_suspend_out(full_suspend_out));
    uhpp_port_model PORTS (.port_out(port_out), .port_in(port_in), .ext_fault(ext_fault),
        .cmp_fault(cmp_fault), .vbus_on(vbus_on));

    // ------------------------------------------------------------
    // Clock, tasks and watchdog
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task step(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : step

    task chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, s, e);
        end
    endtask : chk

    // Classic single cycle; read data lands in q at the ack edge
    task wb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (wb_ack_o !== 1'b1) chk(32'h0, 32'h1);
    endtask : wb

    task summarize();
        $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    // Whole run is about 81k cycles
    initial begin
        step(95000);
        mismatches++;
        summarize();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rstn, cyc, stb, we, soft_reset, sof_pulse, async_int_req} = 7'h0;
        {host_wake_in, chip_select_n, downstream_resume, peripheral_suspended} = 4'h4;
        adr = 10'h0;
        dat = 32'h0;
        ep_frame_bytes = 11'h0;
        ext_fault = 2'h0;
        cmp_fault = 2'h0;
        rows[0] = '{32'h0, 2'h0, 2'h3, 2'h3, 1'b0};
        rows[1] = '{32'h0, 2'h1, 2'h0, 2'h2, 1'b0};
        rows[2] = '{32'h1000, 2'h2, 2'h0, 2'h1, 1'b1};
        rows[3] = '{32'h400, 2'h3, 2'h1, 2'h2, 1'b0};
        rows[4] = '{32'h1400, 2'h0, 2'h2, 2'h1, 1'b1};
        step(10);
        rstn <= 1'b1;
        wb(1'b0, `UHPP_ADDR_HW_CONFIG, 32'h0);
        chk(q, 32'h0);
        chk(vbus_on, 2'h3);
        wb(1'b0, 10'h3fc, 32'h0);
        chk(q, 32'h0);
        // Source select and power switch per table row
        foreach (rows[i]) begin
            wb(1'b1, `UHPP_ADDR_HW_CONFIG, rows[i].cfg);
            ext_fault <= rows[i].ext;
            cmp_fault <= rows[i].cmp;
            step(6);
            chk(vbus_on, rows[i].vbus);
            chk(port_out.pulldown_en, rows[i].pd);
        end
        ext_fault <= 2'h0;
        cmp_fault <= 2'h0;
        // List still busy at frame start silences the async interrupt
        wb(1'b1, `UHPP_ADDR_SCHED, 32'h1);
        sof_pulse <= 1'b1;
        step(1);
        sof_pulse <= 1'b0;
        async_int_req <= 1'b1;
        step(1);
        #1 chk(async_int_pulse, 1'b0);
        wb(1'b1, `UHPP_ADDR_SCHED, 32'h0);
        sof_pulse <= 1'b1;
        step(1);
        sof_pulse <= 1'b0;
        step(1);
        #1 chk(async_int_pulse, 1'b1);
        // Endpoint byte limit at its boundary
        ep_frame_bytes <= 11'h3ff;
        async_int_req <= 1'b0;
        wb(1'b0, `UHPP_ADDR_SCHED, 32'h0);
        chk(q[2], 1'b0);
        ep_frame_bytes <= 11'h400;
        step(2);
        wb(1'b0, `UHPP_ADDR_SCHED, 32'h0);
        chk(q[2], 1'b1);
        ep_frame_bytes <= 11'h0;
        // Suspend with clock stop, then wake pin
        peripheral_suspended <= 1'b1;
        wb(1'b1, `UHPP_ADDR_CPU_INT, 32'h40);
        wb(1'b1, `UHPP_ADDR_CONTROL, 32'hc0);
        step(2);
        chk(host_suspend_out, 1'b1);
        step(25880);
        chk(clock_enable_out, 1'b1);
        chk(full_suspend_out, 1'b0);
        step(200);
        chk(clock_enable_out, 1'b0);
        chk(full_suspend_out, 1'b1);
        host_wake_in <= 1'b1;
        step(3200);
        chk(clock_enable_out, 1'b1);
        wb(1'b0, `UHPP_ADDR_CPU_INT, 32'h0);
        chk(q[6], 1'b1);
        wb(1'b1, `UHPP_ADDR_CPU_INT, 32'h40);
        wb(1'b0, `UHPP_ADDR_CPU_INT, 32'h0);
        chk(q[6], 1'b0);
        step(2000);
        chk(clock_enable_out, 1'b1);
        host_wake_in <= 1'b0;
        step(22000);
        chk(clock_enable_out, 1'b1);
        step(1000);
        chk(clock_enable_out, 1'b0);
        chk(host_suspend_out, 1'b1);
        // Chip select and downstream resume
        chip_select_n <= 1'b0;
        step(10);
        chk(clock_enable_out, 1'b1);
        chip_select_n <= 1'b1;
        downstream_resume <= 1'b1;
        step(5);
        downstream_resume <= 1'b0;
        wb(1'b0, `UHPP_ADDR_CONTROL, 32'h0);
        chk(q[7:6], 2'h1);
        chk(host_suspend_out, 1'b1);
        wb(1'b0, `UHPP_ADDR_INT_STATUS, 32'h0);
        chk(q[6], 1'b1);
        wb(1'b1, `UHPP_ADDR_INT_STATUS, 32'h40);
        wb(1'b0, `UHPP_ADDR_INT_STATUS, 32'h0);
        chk(q[6], 1'b0);
        wb(1'b1, `UHPP_ADDR_CONTROL, 32'h80);
        step(2);
        chk(host_suspend_out, 1'b0);
        // Clock kept during suspend, then bus reset state
        wb(1'b1, `UHPP_ADDR_HW_CONFIG, 32'h800);
        wb(1'b1, `UHPP_ADDR_CONTROL, 32'hc0);
        step(26100);
        chk(clock_enable_out, 1'b1);
        wb(1'b1, `UHPP_ADDR_CONTROL, 32'h0);
        step(2);
        chk(host_suspend_out, 1'b0);
        // Software reset clears the configuration
        wb(1'b1, `UHPP_ADDR_HW_CONFIG, 32'h1400);
        soft_reset <= 1'b1;
        step(1);
        soft_reset <= 1'b0;
        step(2);
        wb(1'b0, `UHPP_ADDR_HW_CONFIG, 32'h0);
        chk(q, 32'h0);
        chk(port_out.pulldown_en, 1'b0);
        // Hardware reset in mid-run clears it too
        wb(1'b1, `UHPP_ADDR_HW_CONFIG, 32'h1400);
        rstn <= 1'b0;
        step(2);
        rstn <= 1'b1;
        wb(1'b0, `UHPP_ADDR_HW_CONFIG, 32'h0);
        chk(q, 32'h0);
        chk(port_out.pulldown_en, 1'b0);
        summarize();
    end
endmodule : uhpp_top_tb
